/* File: rtl/ila_pkg.sv */
// Package: line activation codes, timer figures and carrier structs
package ila_pkg;

  // Clock rate and timer figures
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TN1_MS = 13;
  localparam int unsigned TL1_MS = 7;
  localparam int unsigned TL2_MS = 1;
  localparam int unsigned T2_MS = 1;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned TN1_CYC = TN1_MS * CYC_PER_MS;
  localparam int unsigned TL1_CYC = TL1_MS * CYC_PER_MS;
  localparam int unsigned TL2_CYC = TL2_MS * CYC_PER_MS;
  localparam int unsigned T2_CYC = T2_MS * CYC_PER_MS;
  localparam int unsigned TMR_W = 24;

  // Line signals, both directions
  typedef enum logic [3:0] {
    ILA_SIG0, ILA_SIG1W, ILA_SIG2W, ILA_SIG1, ILA_SIG2, ILA_SIG1A, ILA_SIG3,
    ILA_SIG4H, ILA_SIG4, ILA_SIG5, ILA_SIG2L2, ILA_SIG4HL2, ILA_SIG4L2
  } ila_sig_t;

  // User-side signals
  typedef enum logic [2:0] {
    ILA_INFO0, ILA_INFO1, ILA_INFO2, ILA_INFO3, ILA_INFO4, ILA_INFOX
  } ila_info_t;

  // Network termination states
  typedef enum logic [3:0] {
    NT_1_1, NT_1_2, NT_1_3, NT_1_4, NT_1_5, NT_1_6, NT_1_7, NT_1_8, NT_1_9,
    NT_1_10, NT_2_1, NT_2_2
  } ila_nt_st_t;

  // Line termination states
  typedef enum logic [3:0] {
    LT_1_1, LT_1_2, LT_1_3, LT_1_4, LT_1_5, LT_1_6, LT_1_7, LT_1_8, LT_2_1,
    LT_2_2, LT_2_3, LT_2_4
  } ila_lt_st_t;

  // Network termination observed conditions
  typedef struct packed {
    ila_info_t info;
    ila_sig_t sig;
    logic line_lock;
    logic user_lost;
    logic line_lost;
  } ila_nt_in_t;

  // Network termination drive
  typedef struct packed {
    ila_info_t info;
    ila_sig_t sig;
    logic decho_zero;
    logic loop2;
  } ila_nt_out_t;

  // Line termination observed conditions
  typedef struct packed {
    logic fe1;
    logic fe5;
    ila_sig_t sig;
    logic line_lock;
    logic line_lost;
  } ila_lt_in_t;

  // Line termination drive and exchange events
  typedef struct packed {
    ila_sig_t sig;
    logic fe2;
    logic fe3;
    logic fe4;
    logic fe6;
    logic fe7;
  } ila_lt_out_t;

endpackage

/* File: rtl/ila_line_act.sv */
// Activation state machines for both ends of the subscriber line
`timescale 1ns/1ps

// How it works
// - NT 1.1 is deactivated and sends nothing either way.
// - INFO 1 while deactivated enters NT 1.2 sending SIG 1W.
// - NT 1.3 answers SIG 1W, then SIG 1A after Tn1 without new SIG 2W.
// - NT 1.4 waits for SIG 2 to lock its receiver.
// - NT 1.5 sends SIG 1 and INFO 2, waits for INFO 3.
// - NT 1.6 sends SIG 3, waits for SIG 4H.
// - NT 1.7 fully active, sends INFO 4 and SIG 5.
// - NT 1.8 sends INFO 0 and SIG 0, leaves on INFO 0 or T2.
// - User-side loss enters NT 1.9 sending INFO 2, nothing new to line.
// - Line framing loss enters NT 1.10 sending INFO X and SIG 0.
// - SIG 2-L2 moves NT 1.4, 1.5, 1.6 to NT 2.1.
// - NT 2.1 sends SIG 3 and INFO 2, waits for SIG 4H-L2.
// - SIG 4H-L2 in NT 1.6 or 2.1 enters NT 2.2.
// - SIG 4-L2 in 1.7, 1.9, 1.10 enters NT 2.2, D-echo zero, loop back.
// - FE 1 in LT 1.1 enters LT 1.3 with SIG 2W; SIG 1W goes LT 1.4.
// - SIG 1W in LT 1.1 starts Tl1, issues FE 2, LT 1.2; Tl1 ends LT 1.4.
// - LT 1.4 sends SIG 2; locked with SIG 1 issues FE 3, LT 1.5.
// - SIG 3 in LT 1.4 or 1.5 starts Tl2 and enters LT 1.6.
// - Line framing loss in LT 1.5 to 1.7 issues FE 7.
// - Tn1 lasts 13 ms.
// - Tl1 lasts 7 ms.
// - Tl2 lasts 1 ms.
// - Fully active line termination sends SIG 4 and issues FE 4.
module ila_line_act #(
  parameter int unsigned TN1 = ila_pkg::TN1_CYC,
  parameter int unsigned TL1 = ila_pkg::TL1_CYC,
  parameter int unsigned TL2 = ila_pkg::TL2_CYC,
  parameter int unsigned T2 = ila_pkg::T2_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire ila_pkg::ila_nt_in_t nt_in,
  output ila_pkg::ila_nt_out_t nt_out,
  output ila_pkg::ila_nt_st_t nt_state,
  input wire ila_pkg::ila_lt_in_t lt_in,
  output ila_pkg::ila_lt_out_t lt_out,
  output ila_pkg::ila_lt_st_t lt_state
);
  import ila_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    ila_nt_st_t nt;
    logic [TMR_W-1:0] nt_tmr;
    ila_nt_out_t nto;
    ila_lt_st_t lt;
    logic [TMR_W-1:0] lt_tmr;
    ila_lt_out_t lto;
  } ila_state_t;

  ila_state_t s_q;
  ila_state_t s_d;

  // Timer load value, cut to counter width
  function automatic logic [TMR_W-1:0] tload(input int unsigned cyc);
    tload = TMR_W'(cyc);
  endfunction

  // Timer countdown, stops at zero
  function automatic logic [TMR_W-1:0] tdec(input logic [TMR_W-1:0] t);
    tdec = (t == '0) ? t : t - TMR_W'(1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.nt_tmr = tdec(s_q.nt_tmr);
    s_d.lt_tmr = tdec(s_q.lt_tmr);
    s_d.lto.fe2 = 1'b0;
    s_d.lto.fe3 = 1'b0;
    s_d.lto.fe6 = 1'b0;
    s_d.lto.fe7 = 1'b0;

    // Network termination transitions
    unique case (s_q.nt)
      NT_1_1: begin
        if (nt_in.sig == ILA_SIG2W) begin
          s_d.nt = NT_1_3;
          s_d.nt_tmr = tload(TN1);
        end else if (nt_in.info == ILA_INFO1) begin
          s_d.nt = NT_1_2;
        end
      end
      NT_1_2: begin
        if (nt_in.sig == ILA_SIG2W) begin
          s_d.nt = NT_1_4;
        end
      end
      NT_1_3: begin
        if (nt_in.sig == ILA_SIG2W) begin
          s_d.nt_tmr = tload(TN1);
        end else if (s_q.nt_tmr == TMR_W'(1)) begin
          s_d.nt = NT_1_4;
        end
      end
      NT_1_4: begin
        if (nt_in.sig == ILA_SIG0) begin
          s_d.nt = NT_1_8;
        end else if (nt_in.sig == ILA_SIG2L2) begin
          s_d.nt = NT_2_1;
        end else if (nt_in.sig == ILA_SIG2 && nt_in.line_lock) begin
          s_d.nt = NT_1_5;
        end
      end
      NT_1_5: begin
        if (nt_in.sig == ILA_SIG0) begin
          s_d.nt = NT_1_8;
        end else if (nt_in.line_lost) begin
          s_d.nt = NT_1_10;
        end else if (nt_in.sig == ILA_SIG2L2) begin
          s_d.nt = NT_2_1;
        end else if (nt_in.info == ILA_INFO3) begin
          s_d.nt = NT_1_6;
        end
      end
      NT_1_6: begin
        if (nt_in.sig == ILA_SIG0) begin
          s_d.nt = NT_1_8;
        end else if (nt_in.line_lost) begin
          s_d.nt = NT_1_10;
        end else if (nt_in.sig == ILA_SIG2L2) begin
          s_d.nt = NT_2_1;
        end else if (nt_in.sig == ILA_SIG4HL2) begin
          s_d.nt = NT_2_2;
        end else if (nt_in.sig == ILA_SIG4H) begin
          s_d.nt = NT_1_7;
        end
      end
      NT_1_7: begin
        if (nt_in.sig == ILA_SIG0) begin
          s_d.nt = NT_1_8;
        end else if (nt_in.line_lost) begin
          s_d.nt = NT_1_10;
        end else if (nt_in.sig == ILA_SIG4L2) begin
          s_d.nt = NT_2_2;
        end else if (nt_in.user_lost || nt_in.info == ILA_INFO0) begin
          s_d.nt = NT_1_9;
        end
      end
      NT_1_8: begin
        if (nt_in.info == ILA_INFO0 || s_q.nt_tmr == TMR_W'(1)) begin
          s_d.nt = NT_1_1;
        end
      end
      NT_1_9: begin
        if (nt_in.sig == ILA_SIG0) begin
          s_d.nt = NT_1_8;
        end else if (nt_in.line_lost) begin
          s_d.nt = NT_1_10;
        end else if (nt_in.sig == ILA_SIG4L2) begin
          s_d.nt = NT_2_2;
        end else if (nt_in.info == ILA_INFO3) begin
          s_d.nt = NT_1_7;
        end
      end
      NT_1_10: begin
        if (nt_in.sig == ILA_SIG0) begin
          s_d.nt = NT_1_8;
        end else if (nt_in.sig == ILA_SIG4L2) begin
          s_d.nt = NT_2_2;
        end
      end
      NT_2_1: begin
        if (nt_in.sig == ILA_SIG0) begin
          s_d.nt = NT_1_8;
        end else if (nt_in.line_lost) begin
          s_d.nt = NT_1_10;
        end else if (nt_in.sig == ILA_SIG4HL2) begin
          s_d.nt = NT_2_2;
        end else if (nt_in.sig == ILA_SIG4H) begin
          s_d.nt = NT_1_7;
        end
      end
      NT_2_2: begin
        if (nt_in.sig == ILA_SIG0) begin
          s_d.nt = NT_1_8;
        end else if (nt_in.line_lost) begin
          s_d.nt = NT_1_10;
        end else if (nt_in.sig == ILA_SIG4) begin
          s_d.nt = NT_1_7;
        end
      end
    endcase
    // Start T2 on entry to pending deactivation
    if (s_d.nt == NT_1_8 && s_q.nt != NT_1_8) begin
      s_d.nt_tmr = tload(T2);
    end

    // Network termination drive per next state
    s_d.nto.decho_zero = 1'b0;
    s_d.nto.loop2 = 1'b0;
    unique case (s_d.nt)
      NT_1_1: begin s_d.nto.info = ILA_INFO0; s_d.nto.sig = ILA_SIG0; end
      NT_1_2: begin s_d.nto.info = ILA_INFO0; s_d.nto.sig = ILA_SIG1W; end
      NT_1_3: begin
        s_d.nto.info = ILA_INFO0;
        s_d.nto.sig = ILA_SIG1W;
      end
      NT_1_4: begin s_d.nto.info = ILA_INFO0; s_d.nto.sig = ILA_SIG1A; end
      NT_1_5: begin s_d.nto.info = ILA_INFO2; s_d.nto.sig = ILA_SIG1; end
      NT_1_6: begin s_d.nto.info = ILA_INFO2; s_d.nto.sig = ILA_SIG3; end
      NT_1_7: begin s_d.nto.info = ILA_INFO4; s_d.nto.sig = ILA_SIG5; end
      NT_1_8: begin s_d.nto.info = ILA_INFO0; s_d.nto.sig = ILA_SIG0; end
      NT_1_9: begin s_d.nto.info = ILA_INFO2; s_d.nto.sig = ILA_SIG5; end
      NT_1_10: begin s_d.nto.info = ILA_INFOX; s_d.nto.sig = ILA_SIG0; end
      NT_2_1: begin s_d.nto.info = ILA_INFO2; s_d.nto.sig = ILA_SIG3; end
      NT_2_2: begin
        s_d.nto.info = ILA_INFO4;
        s_d.nto.sig = ILA_SIG5;
        s_d.nto.decho_zero = 1'b1;
        s_d.nto.loop2 = 1'b1;
      end
    endcase

    ////////////////////////////////////////////////////////////////////////////
    // Line termination transitions; FE 5 first
    if (lt_in.fe5 && s_q.lt != LT_1_1 && s_q.lt != LT_1_8) begin
      s_d.lt = LT_1_8;
    end else begin
      unique case (s_q.lt)
        LT_1_1: begin
          if (lt_in.sig == ILA_SIG1W) begin
            s_d.lt = LT_1_2;
            s_d.lt_tmr = tload(TL1);
            s_d.lto.fe2 = 1'b1;
          end else if (lt_in.fe1) begin
            s_d.lt = LT_1_3;
          end
        end
        LT_1_2: begin
          if (lt_in.sig == ILA_SIG1W) begin
            s_d.lt_tmr = tload(TL1);
          end else if (s_q.lt_tmr == TMR_W'(1)) begin
            s_d.lt = LT_1_4;
          end
        end
        LT_1_3: begin
          if (lt_in.sig == ILA_SIG1W) begin
            s_d.lt = LT_1_4;
          end
        end
        LT_1_4: begin
          if (lt_in.sig == ILA_SIG3) begin
            s_d.lt = LT_1_6;
            s_d.lt_tmr = tload(TL2);
          end else if (lt_in.sig == ILA_SIG1 && lt_in.line_lock) begin
            s_d.lt = LT_1_5;
            s_d.lto.fe3 = 1'b1;
          end
        end
        LT_1_5: begin
          if (lt_in.sig == ILA_SIG3) begin
            s_d.lt = LT_1_6;
            s_d.lt_tmr = tload(TL2);
          end
        end
        LT_1_6: begin
          if (s_q.lt_tmr == TMR_W'(1)) begin
            s_d.lt = LT_1_7;
          end
        end
        LT_1_8: begin
          if (lt_in.sig == ILA_SIG0) begin
            s_d.lt = LT_1_1;
            s_d.lto.fe6 = 1'b1;
          end
        end
        LT_2_3: begin
          if (s_q.lt_tmr == TMR_W'(1)) begin
            s_d.lt = LT_2_4;
          end
        end
        default: begin
        end
      endcase
    end
    // Framing loss or silence while synchronised
    if ((lt_in.line_lost || lt_in.sig == ILA_SIG0) &&
        (s_q.lt == LT_1_5 || s_q.lt == LT_1_6 || s_q.lt == LT_1_7)) begin
      s_d.lto.fe7 = 1'b1;
    end

    // Line termination drive per next state
    s_d.lto.fe4 = (s_d.lt == LT_1_7 || s_d.lt == LT_2_4);
    unique case (s_d.lt)
      LT_1_2, LT_1_3, LT_2_1: s_d.lto.sig = ILA_SIG2W;
      LT_1_4, LT_1_5, LT_2_2: s_d.lto.sig = ILA_SIG2;
      LT_1_6, LT_2_3: s_d.lto.sig = ILA_SIG4H;
      LT_1_7, LT_2_4: s_d.lto.sig = ILA_SIG4;
      default: s_d.lto.sig = ILA_SIG0;
    endcase

    // Synchronous reset to deactivated states
    if (!rst_n) begin
      s_d = '0;
      s_d.nt = NT_1_1;
      s_d.lt = LT_1_1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n || clk_en) begin
      s_q <= s_d;
    end
  end

  // Outputs from flip-flops
  assign nt_out = s_q.nto;
  assign nt_state = s_q.nt;
  assign lt_out = s_q.lto;
  assign lt_state = s_q.lt;

endmodule // ila_line_act

/* File: tb/ila_line_act_sva.sv */
// Checker: activation state machine properties at the block ports
`timescale 1ns/1ps
module ila_line_act_sva #(
  parameter int unsigned TN1 = ila_pkg::TN1_CYC,
  parameter int unsigned TL1 = ila_pkg::TL1_CYC,
  parameter int unsigned TL2 = ila_pkg::TL2_CYC,
  parameter int unsigned T2 = ila_pkg::T2_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire ila_pkg::ila_nt_in_t nt_in,
  input wire ila_pkg::ila_nt_out_t nt_out,
  input wire ila_pkg::ila_nt_st_t nt_state,
  input wire ila_pkg::ila_lt_in_t lt_in,
  input wire ila_pkg::ila_lt_out_t lt_out,
  input wire ila_pkg::ila_lt_st_t lt_state
);
  import ila_pkg::*;
  int unsigned tn1_d;
  int unsigned tn1_q;
  // Quiet cycles in NT 1.3 since the last awake tone
  always_comb begin
    tn1_d = tn1_q;
    if (!rst_n) tn1_d = 0;
    else if (clk_en) tn1_d = (nt_state != NT_1_3 || nt_in.sig == ILA_SIG2W) ? 0 : tn1_q + 1;
  end
  always_ff @(posedge core_clk) begin
    tn1_q <= tn1_d;
  end
  ////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Awake stages of each end
  sequence nt_awake_s;
    nt_state == NT_1_2 && nt_out.sig == ILA_SIG1W;
  endsequence
  sequence lt_awake_s;
    lt_state == LT_1_2 && lt_out.fe2 && lt_out.sig == ILA_SIG2W;
  endsequence
  nt_idle_out_a: assert property (
    nt_state == NT_1_1 |-> nt_out.info == ILA_INFO0 && nt_out.sig == ILA_SIG0)
    else $error("idle drive wrong");
  nt_wake_a: assert property (
    clk_en && nt_state == NT_1_1 && nt_in.info == ILA_INFO1 && nt_in.sig == ILA_SIG0
    |=> nt_awake_s) else $error("user wake not taken");
  tn1_expiry_a: assert property (
    clk_en && nt_state == NT_1_3 && nt_in.sig != ILA_SIG2W
    |=> (nt_state == NT_1_4) == ($past(tn1_q) == TN1 - 1)) else $error("Tn1 length wrong");
  nt_full_a: assert property (
    nt_state == NT_1_7 |-> nt_out.info == ILA_INFO4 && nt_out.sig == ILA_SIG5 && !nt_out.loop2)
    else $error("active drive wrong");
  nt_deact_a: assert property (
    clk_en && nt_state == NT_1_8 && nt_in.info == ILA_INFO0 |=> nt_state == NT_1_1)
    else $error("deactivation not done");
  nt_frame_loss_a: assert property (
    clk_en && nt_in.line_lost && nt_in.sig != ILA_SIG0
    && nt_state inside {NT_1_5, NT_1_6, NT_1_7, NT_1_9, NT_2_1, NT_2_2}
    |=> nt_state == NT_1_10 && nt_out.info == ILA_INFOX && nt_out.sig == ILA_SIG0)
    else $error("line loss not taken");
  nt_loop_a: assert property (
    clk_en && nt_in.sig == ILA_SIG4L2 && !nt_in.line_lost
    && nt_state inside {NT_1_7, NT_1_9, NT_1_10}
    |=> nt_state == NT_2_2 && nt_out.loop2 && nt_out.decho_zero) else $error("loop not set");
  lt_wake_a: assert property (
    clk_en && lt_state == LT_1_1 && lt_in.sig == ILA_SIG1W && !lt_in.fe1
    |=> lt_awake_s) else $error("line wake not taken");
  lt_sig3_a: assert property (
    clk_en && lt_state inside {LT_1_4, LT_1_5} && lt_in.sig == ILA_SIG3 && !lt_in.fe5
    && !lt_in.line_lost |=> lt_state == LT_1_6 && lt_out.sig == ILA_SIG4H)
    else $error("SIG 3 not taken");
  lt_loss_a: assert property (
    clk_en && lt_in.line_lost && !lt_in.fe5 && lt_state inside {LT_1_5, LT_1_6, LT_1_7}
    |=> lt_out.fe7) else $error("FE 7 missing");
  lt_fe5_a: assert property (
    clk_en && lt_in.fe5 && !(lt_state inside {LT_1_1, LT_1_8})
    |=> lt_state == LT_1_8 && lt_out.sig == ILA_SIG0) else $error("FE 5 not taken");
  lt_full_a: assert property (
    lt_state == LT_1_7 |-> lt_out.fe4 && lt_out.sig == ILA_SIG4) else $error("LT active wrong");
endmodule // ila_line_act_sva

bind ila_line_act ila_line_act_sva #(.TN1(TN1), .TL1(TL1), .TL2(TL2), .T2(T2)) sva_i (
  .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .nt_in(nt_in), .nt_out(nt_out),
  .nt_state(nt_state), .lt_in(lt_in), .lt_out(lt_out), .lt_state(lt_state));

/* File: tb/ila_user_term.sv */
// Partner: user-side terminal facing the network termination
`timescale 1ns/1ps
module ila_user_term (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic act,
  input wire ila_pkg::ila_info_t from_nt,
  output ila_pkg::ila_info_t to_nt
);
  import ila_pkg::*;
  ila_info_t st_d;
  ila_info_t st_q;
  // Wake with INFO 1, answer INFO 2 or INFO 4 with INFO 3
  always_comb begin
    if (!rst_n || !act) st_d = ILA_INFO0;
    else if (from_nt == ILA_INFO2 || from_nt == ILA_INFO4) st_d = ILA_INFO3;
    else if (from_nt == ILA_INFO0) st_d = ILA_INFO1;
    else st_d = ILA_INFO0;
  end
  always_ff @(posedge core_clk) begin
    st_q <= st_d;
  end
  assign to_nt = st_q;
endmodule // ila_user_term

/* File: tb/ila_line_act_tb.sv */
// Testbench: activation state machines of both line ends
`timescale 1ns/1ps
module ila_line_act_tb;
  import ila_pkg::*;
  localparam int unsigned TMR = 5;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic act = 1'b0;
  ila_nt_in_t nt_i = '0;
  ila_lt_in_t lt_in = '0;
  ila_nt_in_t nt_in;
  ila_info_t u_info;
  ila_nt_out_t nt_out;
  ila_nt_st_t nt_state;
  ila_lt_out_t lt_out;
  ila_lt_st_t lt_state;
  int num_errors = 0;
  int tests_run = 0;
  // Clock and user-side merge
  always #50 core_clk = ~core_clk;
  assign nt_in = {u_info, nt_i.sig, nt_i.line_lock, nt_i.user_lost, nt_i.line_lost};
  ila_line_act #(.TN1(TMR), .TL1(TMR), .TL2(TMR), .T2(TMR)) ila_line_act_i (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .nt_in(nt_in), .nt_out(nt_out),
    .nt_state(nt_state), .lt_in(lt_in), .lt_out(lt_out), .lt_state(lt_state));
  ila_user_term ila_user_term_i (.core_clk(core_clk), .rst_n(rst_n), .act(act),
    .from_nt(nt_out.info), .to_nt(u_info));
  ////////////////////////////////////////
  task automatic tk(int n = 1);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(string what, logic [12:0] seen, logic [12:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic nt_exp(ila_nt_st_t s, ila_info_t i, ila_sig_t g, logic [1:0] f);
    @(negedge core_clk);
    chk("nt", {nt_state, nt_out}, {s, i, g, f});
  endtask
  task automatic lt_exp(ila_lt_st_t s, ila_sig_t g, logic [4:0] f);
    @(negedge core_clk);
    chk("lt", {lt_state, lt_out}, {s, g, f});
  endtask
  task automatic do_reset;
    tk;
    rst_n <= 1'b0;
    nt_i <= '0;
    lt_in <= '0;
    act <= 1'b0;
    clk_en <= 1'b1;
    tk(5);
    rst_n <= 1'b1;
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Full user-woken activation, losses, loopback and T2
  task automatic t_nt_full;
    do_reset;
    nt_exp(NT_1_1, ILA_INFO0, ILA_SIG0, 2'h0);
    tk;
    act <= 1'b1;
    tk(2);
    nt_exp(NT_1_2, ILA_INFO0, ILA_SIG1W, 2'h0);
    tk;
    nt_i.sig <= ILA_SIG2W;
    tk;
    nt_exp(NT_1_4, ILA_INFO0, ILA_SIG1A, 2'h0);
    tk;
    nt_i.sig <= ILA_SIG2;
    nt_i.line_lock <= 1'b1;
    tk;
    nt_exp(NT_1_5, ILA_INFO2, ILA_SIG1, 2'h0);
    tk(2);
    nt_exp(NT_1_6, ILA_INFO2, ILA_SIG3, 2'h0);
    tk;
    nt_i.sig <= ILA_SIG4H;
    tk;
    nt_exp(NT_1_7, ILA_INFO4, ILA_SIG5, 2'h0);
    tk;
    nt_i.sig <= ILA_SIG4;
    nt_i.user_lost <= 1'b1;
    tk;
    nt_i.user_lost <= 1'b0;
    nt_exp(NT_1_9, ILA_INFO2, ILA_SIG5, 2'h0);
    tk;
    nt_exp(NT_1_7, ILA_INFO4, ILA_SIG5, 2'h0);
    tk;
    nt_i.line_lost <= 1'b1;
    tk;
    nt_i.line_lost <= 1'b0;
    nt_exp(NT_1_10, ILA_INFOX, ILA_SIG0, 2'h0);
    tk;
    nt_i.sig <= ILA_SIG4L2;
    tk;
    nt_exp(NT_2_2, ILA_INFO4, ILA_SIG5, 2'h3);
    tk;
    nt_i.sig <= ILA_SIG0;
    tk;
    for (int i = 0; i < TMR; i++) begin
      nt_exp(NT_1_8, ILA_INFO0, ILA_SIG0, 2'h0);
      tk;
    end
    nt_exp(NT_1_1, ILA_INFO0, ILA_SIG0, 2'h0);
  endtask
  // Line-woken start, Tn1 length, loopback 2 and frozen clock enable
  task automatic t_nt_tn1;
    do_reset;
    tk;
    nt_i.sig <= ILA_SIG2W;
    tk(3);
    nt_i.sig <= ILA_SIG2;
    for (int i = 0; i < TMR; i++) begin
      nt_exp(NT_1_3, ILA_INFO0, ILA_SIG1W, 2'h0);
      tk;
    end
    nt_exp(NT_1_4, ILA_INFO0, ILA_SIG1A, 2'h0);
    tk;
    nt_i.sig <= ILA_SIG2L2;
    tk;
    nt_exp(NT_2_1, ILA_INFO2, ILA_SIG3, 2'h0);
    tk;
    clk_en <= 1'b0;
    nt_i.sig <= ILA_SIG4HL2;
    tk(3);
    clk_en <= 1'b1;
    nt_exp(NT_2_1, ILA_INFO2, ILA_SIG3, 2'h0);
    tk;
    nt_exp(NT_2_2, ILA_INFO4, ILA_SIG5, 2'h3);
    tk;
    nt_i.sig <= ILA_SIG0;
    tk;
    nt_exp(NT_1_8, ILA_INFO0, ILA_SIG0, 2'h0);
    tk;
    nt_exp(NT_1_1, ILA_INFO0, ILA_SIG0, 2'h0);
  endtask
  // Line termination woken by the line, up to full activation and back
  task automatic t_lt_full;
    do_reset;
    tk;
    lt_in.sig <= ILA_SIG1W;
    tk;
    lt_in.sig <= ILA_SIG0;
    lt_exp(LT_1_2, ILA_SIG2W, 5'h10);
    for (int i = 1; i < TMR; i++) begin
      tk;
      lt_exp(LT_1_2, ILA_SIG2W, 5'h00);
    end
    tk;
    lt_exp(LT_1_4, ILA_SIG2, 5'h00);
    tk;
    lt_in.sig <= ILA_SIG1;
    lt_in.line_lock <= 1'b1;
    tk;
    lt_exp(LT_1_5, ILA_SIG2, 5'h08);
    tk;
    lt_in.sig <= ILA_SIG3;
    for (int i = 0; i < TMR; i++) begin
      tk;
      lt_exp(LT_1_6, ILA_SIG4H, 5'h00);
    end
    tk;
    lt_exp(LT_1_7, ILA_SIG4, 5'h04);
    tk;
    lt_in.line_lost <= 1'b1;
    tk;
    lt_in.line_lost <= 1'b0;
    lt_exp(LT_1_7, ILA_SIG4, 5'h05);
    tk;
    lt_in.fe5 <= 1'b1;
    tk;
    lt_in.fe5 <= 1'b0;
    lt_exp(LT_1_8, ILA_SIG0, 5'h00);
    tk;
    lt_in.sig <= ILA_SIG0;
    tk;
    lt_exp(LT_1_1, ILA_SIG0, 5'h02);
  endtask
  // Exchange-woken start of the line termination
  task automatic t_lt_fe1;
    do_reset;
    tk;
    lt_in.fe1 <= 1'b1;
    tk;
    lt_in.fe1 <= 1'b0;
    lt_exp(LT_1_3, ILA_SIG2W, 5'h00);
    tk;
    lt_in.sig <= ILA_SIG1W;
    tk;
    lt_exp(LT_1_4, ILA_SIG2, 5'h00);
    tk;
    lt_in.sig <= ILA_SIG3;
    tk;
    lt_exp(LT_1_6, ILA_SIG4H, 5'h00);
  endtask
  // Main sequence
  initial begin
    t_nt_full;
    t_nt_tn1;
    t_lt_full;
    t_lt_fe1;
    give_verdict;
  end
  // Watchdog, well beyond the hundred or so cycles the run needs
  initial begin
    tk(3000);
    num_errors++;
    give_verdict;
  end
endmodule // ila_line_act_tb
